// ===== dbc_pkg.sv
// Purpose: Constants and carrier types for the dual buck control register slice.
// Assumes: Eight-bit register map, one logic clock, synchronous active-low reset.
// Notes:   Decoded figures are in mA, mV and 0.01 mV/us units.
`default_nettype none
package dbc_pkg;
	// Register offsets
	localparam logic [7:0] OFS_FIRST_LIMIT_SLEW  = 8'h03;
	localparam logic [7:0] OFS_SECOND_CONTROL    = 8'h04;
	localparam logic [7:0] OFS_SECOND_LIMIT_SLEW = 8'h05;
	localparam logic [7:0] OFS_FIRST_VOLT_CODE   = 8'h06;
	localparam logic [7:0] OFS_SECOND_VOLT_CODE  = 8'h07;
	// Field positions
	localparam int POS_LIMIT       = 3;
	localparam int POS_RAMP        = 0;
	localparam int POS_FORCED_PWM  = 3;
	localparam int POS_DISCHARGE   = 2;
	localparam int POS_PIN_GATING  = 1;
	localparam int POS_SW_ENABLE   = 0;
	// Reset values
	localparam logic [7:0] RST_LIMIT_SLEW  = 8'h2a;
	localparam logic [7:0] RST_CONTROL     = 8'h07;
	localparam logic [7:0] RST_FIRST_VOLT  = 8'h6b;
	localparam logic [7:0] RST_SECOND_VOLT = 8'h59;
	// Current limit decode, mA
	localparam logic [11:0] LIMIT_BASE_MA = 12'd1500;
	localparam logic [11:0] LIMIT_STEP_MA = 12'd500;
	localparam logic [2:0]  LIMIT_MAX_CODE = 3'h5;
	// Voltage regions, mV
	localparam logic [7:0]  VREG_A_LO = 8'h14;
	localparam logic [7:0]  VREG_B_LO = 8'h18;
	localparam logic [7:0]  VREG_C_LO = 8'h9e;
	localparam logic [11:0] VREG_A_BASE = 12'd700;
	localparam logic [11:0] VREG_B_BASE = 12'd735;
	localparam logic [11:0] VREG_C_BASE = 12'd1420;
	localparam logic [11:0] VREG_A_STEP = 12'd10;
	localparam logic [11:0] VREG_B_STEP = 12'd5;
	localparam logic [11:0] VREG_C_STEP = 12'd20;
	// Ramp rates in 0.01 mV/us
	localparam logic [9:0] RAMP_C2 = 10'd1000;
	localparam logic [9:0] RAMP_C3 = 10'd750;
	localparam logic [9:0] RAMP_C4 = 10'd380;
	localparam logic [9:0] RAMP_C5 = 10'd190;
	localparam logic [9:0] RAMP_C6 = 10'd94;
	localparam logic [9:0] RAMP_C7 = 10'd47;

	// Decoded settings of one converter
	typedef struct packed {
		logic [2:0]  limit_code;
		logic [11:0] limit_ma;
		logic [2:0]  ramp_code;
		logic [9:0]  ramp_rate;
		logic [7:0]  volt_code;
		logic [11:0] vout_mv;
	} dbc_conv_t;

	// All state of the register slice
	typedef struct packed {
		logic [7:0] first_buck_limit_slew;
		logic [7:0] second_buck_control;
		logic [7:0] second_buck_limit_slew;
		logic [7:0] first_buck_voltage_code;
		logic [7:0] second_buck_voltage_code;
		logic [7:0] rdata;
		logic       rvalid;
	} dbc_state_t;
endpackage : dbc_pkg
`default_nettype wire

// ===== dbc_regs.sv
// Purpose: Register slice for two buck converters behind the serial port's register access.
// Assumes: The serial front end presents one-cycle write and read strobes with address.
// Notes:   Decoded outputs follow the registers combinationally; read data is registered.
`timescale 1ns/1ns
`default_nettype none
module dbc_regs
	import dbc_pkg::*;
(
	input  wire logic       clk,            // Logic clock, 20 MHz
	input  wire logic       nrst,           // Synchronous reset, active low
	input  wire logic       reg_wr,         // Write strobe, one cycle
	input  wire logic       reg_rd,         // Read strobe, one cycle
	input  wire logic [7:0] reg_addr,       // Register offset
	input  wire logic [7:0] reg_wdata,      // Write data
	output logic      [7:0] reg_rdata,      // Read data, registered
	output logic            reg_rvalid,     // Read data valid, one cycle
	input  wire logic       en_pin,         // External enable pin level
	output dbc_conv_t       first_conv,     // First converter settings
	output dbc_conv_t       second_conv,    // Second converter settings
	output logic            second_conv_forced_pwm,   // Forced PWM select
	output logic            second_conv_pin_gating,   // Pin gating select
	output logic            second_conv_sw_enable,    // Software enable bit
	output logic            second_conv_run,          // Converter enabled
	output logic            second_conv_discharge_on  // Discharge resistor applied
);

	dbc_state_t st_q;
	dbc_state_t st_d;

	// Current limit code to mA; reserved codes show zero
	function automatic logic [11:0] limit_ma_f(input logic [2:0] c);
		if (c > LIMIT_MAX_CODE) begin
			return 12'h000;
		end
		return LIMIT_BASE_MA + LIMIT_STEP_MA * {9'h000, c};
	endfunction : limit_ma_f

	// Ramp code to rate, used for both step directions
	function automatic logic [9:0] ramp_f(input logic [2:0] c);
		case (c)
			3'h2: return RAMP_C2;
			3'h3: return RAMP_C3;
			3'h4: return RAMP_C4;
			3'h5: return RAMP_C5;
			3'h6: return RAMP_C6;
			3'h7: return RAMP_C7;
			default: return 10'h000;
		endcase
	endfunction : ramp_f

	// Voltage code to mV over three step regions
	function automatic logic [11:0] vout_f(input logic [7:0] c);
		logic [11:0] cw;
		cw = {4'h0, c};
		if (c >= VREG_C_LO) begin
			return VREG_C_BASE + VREG_C_STEP * (cw - {4'h0, VREG_C_LO});
		end else if (c >= VREG_B_LO) begin
			return VREG_B_BASE + VREG_B_STEP * (cw - {4'h0, VREG_B_LO});
		end else if (c >= VREG_A_LO) begin
			return VREG_A_BASE + VREG_A_STEP * (cw - {4'h0, VREG_A_LO});
		end
		return 12'h000;
	endfunction : vout_f

	// Register writes and reads; all bits stored, reserved ones included
	always_comb begin
		st_d        = st_q;
		st_d.rvalid = 1'b0;
		if (reg_wr) begin
			if (reg_addr == OFS_FIRST_LIMIT_SLEW) begin
				st_d.first_buck_limit_slew = reg_wdata;
			end else if (reg_addr == OFS_SECOND_CONTROL) begin
				st_d.second_buck_control = reg_wdata;
			end else if (reg_addr == OFS_SECOND_LIMIT_SLEW) begin
				st_d.second_buck_limit_slew = reg_wdata;
			end else if (reg_addr == OFS_FIRST_VOLT_CODE) begin
				st_d.first_buck_voltage_code = reg_wdata;
			end else if (reg_addr == OFS_SECOND_VOLT_CODE) begin
				st_d.second_buck_voltage_code = reg_wdata;
			end
		end
		if (reg_rd) begin
			st_d.rvalid = 1'b1;
			if (reg_addr == OFS_FIRST_LIMIT_SLEW) begin
				st_d.rdata = st_q.first_buck_limit_slew;
			end else if (reg_addr == OFS_SECOND_CONTROL) begin
				st_d.rdata = st_q.second_buck_control;
			end else if (reg_addr == OFS_SECOND_LIMIT_SLEW) begin
				st_d.rdata = st_q.second_buck_limit_slew;
			end else if (reg_addr == OFS_FIRST_VOLT_CODE) begin
				st_d.rdata = st_q.first_buck_voltage_code;
			end else if (reg_addr == OFS_SECOND_VOLT_CODE) begin
				st_d.rdata = st_q.second_buck_voltage_code;
			end else begin
				st_d.rdata = 8'h00;
			end
		end
	end

	// State register with power-on defaults
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= '{first_buck_limit_slew:    RST_LIMIT_SLEW,
			          second_buck_control:      RST_CONTROL,
			          second_buck_limit_slew:   RST_LIMIT_SLEW,
			          first_buck_voltage_code:  RST_FIRST_VOLT,
			          second_buck_voltage_code: RST_SECOND_VOLT,
			          rdata:                    8'h00,
			          rvalid:                   1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata  = st_q.rdata;
	assign reg_rvalid = st_q.rvalid;

	// Decoded converter settings; reserved bits 7:6 not used
	always_comb begin
		first_conv.limit_code  = st_q.first_buck_limit_slew[POS_LIMIT +: 3];
		first_conv.limit_ma    = limit_ma_f(first_conv.limit_code);
		first_conv.ramp_code   = st_q.first_buck_limit_slew[POS_RAMP +: 3];
		first_conv.ramp_rate   = ramp_f(first_conv.ramp_code);
		first_conv.volt_code   = st_q.first_buck_voltage_code;
		first_conv.vout_mv     = vout_f(first_conv.volt_code);
		second_conv.limit_code = st_q.second_buck_limit_slew[POS_LIMIT +: 3];
		second_conv.limit_ma   = limit_ma_f(second_conv.limit_code);
		second_conv.ramp_code  = st_q.second_buck_limit_slew[POS_RAMP +: 3];
		second_conv.ramp_rate  = ramp_f(second_conv.ramp_code);
		second_conv.volt_code  = st_q.second_buck_voltage_code;
		second_conv.vout_mv    = vout_f(second_conv.volt_code);
	end

	// Second converter mode, enable and discharge
	assign second_conv_forced_pwm   = st_q.second_buck_control[POS_FORCED_PWM];
	assign second_conv_pin_gating   = st_q.second_buck_control[POS_PIN_GATING];
	assign second_conv_sw_enable    = st_q.second_buck_control[POS_SW_ENABLE];
	assign second_conv_run          = second_conv_sw_enable
	                                  & (en_pin | ~second_conv_pin_gating);
	assign second_conv_discharge_on = st_q.second_buck_control[POS_DISCHARGE]
	                                  & ~second_conv_run;

	// Checks on the decoded outputs and on register readback
	a_limit_live_update: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_addr == OFS_SECOND_LIMIT_SLEW
		|=> second_conv.limit_code == $past(reg_wdata[5:3]))
		else $error("current limit not applied after write");
	a_limit_ma_value: assert property (@(posedge clk) disable iff (!nrst)
		first_conv.limit_code <= 3'h5
		|-> first_conv.limit_ma == 12'd1500 + 12'd500 * {9'h000, first_conv.limit_code})
		else $error("current limit decode wrong");
	a_ramp_code_two: assert property (@(posedge clk) disable iff (!nrst)
		second_conv.ramp_code == 3'h2 |-> second_conv.ramp_rate == 10'd1000)
		else $error("ramp code two decode wrong");
	a_ramp_held_steady: assert property (@(posedge clk) disable iff (!nrst)
		!(reg_wr && reg_addr == OFS_FIRST_LIMIT_SLEW) |=> $stable(first_conv.ramp_rate))
		else $error("ramp rate moved without write");
	a_forced_pwm_bit: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_addr == OFS_SECOND_CONTROL
		|=> second_conv_forced_pwm == $past(reg_wdata[3]))
		else $error("forced pwm bit wrong");
	a_discharge_idle: assert property (@(posedge clk) disable iff (!nrst)
		second_conv_run |-> !second_conv_discharge_on)
		else $error("discharge while running");
	a_sw_only_ctrl: assert property (@(posedge clk) disable iff (!nrst)
		!second_conv_pin_gating |-> second_conv_run == second_conv_sw_enable)
		else $error("pin affects run without gating");
	a_sw_enable_off: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_addr == OFS_SECOND_CONTROL && !reg_wdata[0] |=> !second_conv_run)
		else $error("converter runs after software disable");
	a_pin_gate_run: assert property (@(posedge clk) disable iff (!nrst)
		second_conv_pin_gating && !en_pin |-> !second_conv_run)
		else $error("converter runs with pin low");
	a_vout_low_band: assert property (@(posedge clk) disable iff (!nrst)
		first_conv.volt_code == 8'h17 |-> first_conv.vout_mv == 12'd730)
		else $error("low band voltage wrong");
	a_vout_mid_band: assert property (@(posedge clk) disable iff (!nrst)
		first_conv.volt_code == 8'h9d |-> first_conv.vout_mv == 12'd1400)
		else $error("mid band voltage wrong");
	a_vout_high_band: assert property (@(posedge clk) disable iff (!nrst)
		second_conv.volt_code == 8'hff |-> second_conv.vout_mv == 12'd3360)
		else $error("high band voltage wrong");
	a_reserved_readback: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_addr == OFS_FIRST_LIMIT_SLEW ##1 reg_rd && !reg_wr
		&& reg_addr == OFS_FIRST_LIMIT_SLEW
		|=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
		else $error("readback differs from write");

	// Read valid is a one-cycle answer to each read strobe
	a_read_valid_next: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd |=> reg_rvalid)
		else $error("read valid missing after read strobe");
	a_read_valid_drop: assert property (@(posedge clk) disable iff (!nrst)
		!reg_rd |=> !reg_rvalid)
		else $error("read valid without read strobe");

	// Live limit update, discharge bit and enable gating
	a_first_limit_update: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_addr == OFS_FIRST_LIMIT_SLEW
		|=> first_conv.limit_code == $past(reg_wdata[5:3]))
		else $error("first current limit not applied after write");
	a_discharge_bit_off: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_addr == OFS_SECOND_CONTROL && !reg_wdata[2]
		|=> !second_conv_discharge_on)
		else $error("discharge applied with bit clear");
	a_pin_gate_both: assert property (@(posedge clk) disable iff (!nrst)
		second_conv_pin_gating && second_conv_sw_enable && en_pin |-> second_conv_run)
		else $error("converter stopped with bit and pin high");

	// Ramp and voltage decode end points
	a_ramp_code_seven: assert property (@(posedge clk) disable iff (!nrst)
		first_conv.ramp_code == 3'h7 |-> first_conv.ramp_rate == 10'd47)
		else $error("ramp code seven decode wrong");
	a_vout_low_start: assert property (@(posedge clk) disable iff (!nrst)
		first_conv.volt_code == 8'h14 |-> first_conv.vout_mv == 12'd700)
		else $error("low band start voltage wrong");
	a_vout_mid_start: assert property (@(posedge clk) disable iff (!nrst)
		second_conv.volt_code == 8'h18 |-> second_conv.vout_mv == 12'd735)
		else $error("mid band start voltage wrong");
	a_vout_high_start: assert property (@(posedge clk) disable iff (!nrst)
		second_conv.volt_code == 8'h9e |-> second_conv.vout_mv == 12'd1420)
		else $error("high band start voltage wrong");

endmodule : dbc_regs
`default_nettype wire

// ===== dbc_host.sv
// Purpose: Host model that programs the register slice.
// Assumes: One-cycle strobes taken at the rising edge.
// Notes:   Idle address and data carry the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module dbc_host (
	input  wire logic       clk,        // Logic clock
	output logic            reg_wr,     // Write strobe
	output logic            reg_rd,     // Read strobe
	output logic      [7:0] reg_addr,   // Offset
	output logic      [7:0] reg_wdata,  // Write data
	input  wire logic [7:0] reg_rdata,  // Read data
	input  wire logic       reg_rvalid  // Read valid
);
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One write, then release
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// One read, data taken in the valid cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask : rd
	// Write, then read the same offset in the very next cycle
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b1;
		reg_wdata <= ~d;
		@(posedge clk);
		reg_rd    <= 1'b0;
		reg_addr  <= ~a;
		@(negedge clk);
		q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask : wr_rd
endmodule : dbc_host
`default_nettype wire

// ===== dbc_regs_tb.sv
// Purpose: Self-checking bench for the dual buck register slice.
// Assumes: Host model drives the register port.
// Notes:   Expected decodes are computed from a shadow register copy.
`timescale 1ns/1ns
`default_nettype none
module dbc_regs_tb;
	import dbc_pkg::*;
	logic       clk, nrst, en_pin, reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rb, d;
	logic       fpwm, gate, swen, run, dis;
	dbc_conv_t  first_conv, second_conv;
	logic [7:0] mdl [3:7];
	logic [7:0] cv [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};
	int         failures, num_checks, a;
	dbc_regs dbc_regs_inst (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .en_pin(en_pin), .first_conv(first_conv),
		.second_conv(second_conv), .second_conv_forced_pwm(fpwm),
		.second_conv_pin_gating(gate), .second_conv_sw_enable(swen),
		.second_conv_run(run), .second_conv_discharge_on(dis));
	dbc_host dbc_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// Clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Expected decodes
	function automatic logic [15:0] lim(input logic [2:0] c);
		return (c > 3'h5) ? 16'h0000 : 16'h05dc + 16'h01f4 * 16'(c);
	endfunction : lim
	function automatic logic [15:0] ramp(input logic [2:0] c);
		case (c)
			3'h2: return 16'h03e8;
			3'h3: return 16'h02ee;
			3'h4: return 16'h017c;
			3'h5: return 16'h00be;
			3'h6: return 16'h005e;
			3'h7: return 16'h002f;
			default: return 16'h0000;
		endcase
	endfunction : ramp
	function automatic logic [15:0] vout(input logic [7:0] c);
		if (c < 8'h14) return 16'h0000;
		if (c < 8'h18) return 16'h02bc + 16'h000a * 16'(c - 8'h14);
		if (c < 8'h9e) return 16'h02df + 16'h0005 * 16'(c - 8'h18);
		return 16'h058c + 16'h0014 * 16'(c - 8'h9e);
	endfunction : vout
	// One converter's decoded fields
	task automatic chk_conv(input dbc_conv_t c, input logic [7:0] ls, input logic [7:0] v);
		chk(16'(c.limit_code), 16'(ls[5:3]));
		chk(16'(c.limit_ma), lim(ls[5:3]));
		chk(16'(c.ramp_code), 16'(ls[2:0]));
		chk(16'(c.ramp_rate), ramp(ls[2:0]));
		chk(16'(c.volt_code), 16'(v));
		chk(16'(c.vout_mv), vout(v));
	endtask : chk_conv
	// All decoded and control outputs against the shadow copy
	task automatic chk_all();
		logic r;
		@(negedge clk);
		r = mdl[4][0] & (en_pin | ~mdl[4][1]);
		chk_conv(first_conv, mdl[3], mdl[6]);
		chk_conv(second_conv, mdl[5], mdl[7]);
		chk(16'(fpwm), 16'(mdl[4][3]));
		chk(16'(gate), 16'(mdl[4][1]));
		chk(16'(swen), 16'(mdl[4][0]));
		chk(16'(run), 16'(r));
		chk(16'(dis), 16'(mdl[4][2] & ~r));
	endtask : chk_all
	// Legal random data per register
	function automatic logic [7:0] gen(input int a);
		if (a == 3 || a == 5)
			return {2'($urandom), 3'($urandom % 6), 3'(2 + $urandom % 6)};
		if (a == 4) return 8'($urandom);
		return 8'(8'h14 + $urandom % 236);
	endfunction : gen
	// Verdict
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		wrap_up();
	end
	// Main sequence
	initial begin
		nrst = 1'b0;
		en_pin = 1'b1;
		void'($urandom(32'ha818));
		mdl = '{8'h2a, 8'h07, 8'h2a, 8'h6b, 8'h59};
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		chk_all();
		for (a = 2; a < 9; a++) begin
			dbc_host_inst.rd(8'(a), rb);
			chk(16'(rb), (a < 3 || a > 7) ? 16'h0000 : 16'(mdl[a]));
		end
		for (a = 0; a < 32; a++) begin
			@(posedge clk) en_pin <= a[4];
			mdl[4] = {4'($urandom), a[3:0]};
			dbc_host_inst.wr(8'h04, mdl[4]);
			chk_all();
		end
		for (int i = 0; i < 60; i++) begin
			a = 3 + $urandom % 5;
			d = gen(a);
			@(posedge clk) en_pin <= 1'($urandom);
			dbc_host_inst.wr(8'(a), d);
			mdl[a] = d;
			chk_all();
			dbc_host_inst.rd(8'(a), rb);
			chk(16'(rb), 16'(d));
		end
		// Back-to-back write and read, reserved bits set, slowest ramp
		dbc_host_inst.wr_rd(8'h03, 8'hef, rb);
		mdl[3] = 8'hef;
		chk(16'(rb), 16'(mdl[3]));
		chk_all();
		foreach (cv[i]) begin
			mdl[6] = cv[i];
			mdl[7] = cv[5 - i];
			dbc_host_inst.wr(8'h06, mdl[6]);
			dbc_host_inst.wr(8'h07, mdl[7]);
			chk_all();
		end
		wrap_up();
	end
endmodule : dbc_regs_tb
`default_nettype wire
